// ===== rtl/ohi_tx_overhead_insert.sv
`timescale 1ns/1ps
`include "ohi_regs.svh"

// Transmit overhead insertion port. Method 1 runs on the system clock and makes the
// overhead bit clock itself; method 2 runs on the line input clock that the
// terminal equipment shares. Either way the result reaches the framer as one
// overhead bit per slot on the system clock.
module ohi_tx_overhead_insert import ohi_pkg::*; #(
  parameter int M1_HALF_CYCLES = `OHI_M1_HALF_CYCLES,
  parameter int M1_GAP_CYCLES  = `OHI_M1_GAP_CYCLES,
  parameter int M2_GAP_CYCLES  = `OHI_M2_GAP_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        txLineInputClock,
  input  wire logic        ohMethodSel,
  input  wire logic        ohInsertRequest,
  input  wire logic        ohBitIn,
  input  wire logic [15:0] intOhBits,
  output logic             ohBitClock,
  output logic             ohFrameMarkerBitClk,
  output logic             ohFrameMarkerLineClk,
  output logic             ohSlotStrobe,
  output ohi_slot_t        slotOut
);

  function automatic logic isInsertable(input logic [3:0] slot);
    isInsertable = (slot == `OHI_SLOT_A) || (slot == `OHI_SLOT_N);
  endfunction

  // System clock side: synchronised pins and the handshake toggle.
  logic [3:0]    syncClkIn;
  logic [3:0]    syncClkOut;
  logic          syncBit;
  logic          syncReq;
  logic          syncMethod;
  logic          syncTog;

  // Line clock side: synchronised reset and mode.
  logic [1:0]    syncLinkIn;
  logic [1:0]    syncLinkOut;
  logic          linkRst;
  logic          linkMethod;

  // Method 1 machine.
  ohi_m1_state_t m1State_q;
  ohi_m1_state_t m1State_d;
  logic [15:0]   m1Cnt_q;
  logic [15:0]   m1Cnt_d;
  logic [3:0]    m1Slot_q;
  logic [3:0]    m1Slot_d;
  logic          bitClk_q;
  logic          bitClk_d;
  logic          m1Marker_q;
  logic          m1Marker_d;
  logic          m1Latch;
  logic          m1Done;
  logic          m1CntZero;
  ohi_ins_t      m1Ins_q;

  // Method 2 machine.
  ohi_m2_state_t m2State_q;
  ohi_m2_state_t m2State_d;
  logic [15:0]   m2Cnt_q;
  logic [15:0]   m2Cnt_d;
  logic [3:0]    m2Slot_q;
  logic [3:0]    m2Slot_d;
  logic          strobe_q;
  logic          strobe_d;
  logic          m2Marker_q;
  logic          m2Marker_d;
  logic          m2Latch;
  logic          m2CntZero;
  ohi_ins_t      linkWord_q;
  logic          linkTog_q;

  // Hand-off to the framer.
  logic          togSeen_q;
  ohi_ins_t      m2Word_q;
  logic          m2New;
  ohi_ins_t      srcIns;
  logic          srcValid;
  logic          insertOk;
  ohi_slot_t     slotOut_q;
  ohi_slot_t     slotOut_d;

  localparam logic [15:0] M1_HALF_LOAD = 16'(M1_HALF_CYCLES - 1);
  localparam logic [15:0] M1_GAP_LOAD  = 16'(M1_GAP_CYCLES - 1);
  localparam logic [15:0] M2_GAP_LOAD  = 16'(M2_GAP_CYCLES - 1);

  assign syncClkIn  = {linkTog_q, ohMethodSel, ohInsertRequest, ohBitIn};
  assign syncBit    = syncClkOut[0];
  assign syncReq    = syncClkOut[1];
  assign syncMethod = syncClkOut[2];
  assign syncTog    = syncClkOut[3];

  ohi_sync #(
    .WIDTH   (4)
  ) u_sync_clk (
    .clk     (clk),
    .asyncIn (syncClkIn),
    .syncOut (syncClkOut)
  );

  assign syncLinkIn = {rst, ohMethodSel};
  assign linkMethod = syncLinkOut[0];
  assign linkRst    = syncLinkOut[1];

  ohi_sync #(
    .WIDTH   (2)
  ) u_sync_link (
    .clk     (txLineInputClock),
    .asyncIn (syncLinkIn),
    .syncOut (syncLinkOut)
  );

  // Method 1: the bit clock runs only through the sixteen overhead slots of a
  // frame and rests low in between, so edge counting restarts cleanly each frame.
  assign m1CntZero = (m1Cnt_q == 16'h0000);
  assign m1Latch   = (m1State_q == M1_HI) && m1CntZero;
  assign m1Done    = (m1State_q == M1_LO) && m1CntZero;

  always_comb begin
    m1State_d  = m1State_q;
    m1Cnt_d    = m1Cnt_q - 16'h0001;
    m1Slot_d   = m1Slot_q;
    bitClk_d   = bitClk_q;
    m1Marker_d = m1Marker_q;
    case (m1State_q)
      M1_GAP: begin
        if (syncMethod) begin
          m1Cnt_d    = M1_GAP_LOAD;
          m1Marker_d = 1'b0;
        end else if (m1CntZero) begin
          // Rising edge 0 of the frame; the marker has been up for one cycle.
          m1State_d = M1_HI;
          m1Cnt_d   = M1_HALF_LOAD;
          m1Slot_d  = `OHI_SLOT_FIRST;
          bitClk_d  = 1'b1;
        end else if (m1Cnt_q == 16'h0001) begin
          m1Marker_d = 1'b1;
        end
      end
      M1_HI: begin
        if (m1CntZero) begin
          // Falling edge: request and data are taken here.
          m1State_d  = M1_LO;
          m1Cnt_d    = M1_HALF_LOAD;
          bitClk_d   = 1'b0;
          m1Marker_d = 1'b0;
        end
      end
      M1_LO: begin
        if (m1CntZero) begin
          if (m1Slot_q == `OHI_SLOT_LAST) begin
            m1State_d = M1_GAP;
            m1Cnt_d   = M1_GAP_LOAD;
          end else begin
            m1State_d = M1_HI;
            m1Cnt_d   = M1_HALF_LOAD;
            m1Slot_d  = m1Slot_q + 4'h1;
            bitClk_d  = 1'b1;
          end
        end
      end
      default: begin
        m1State_d  = M1_GAP;
        m1Cnt_d    = M1_GAP_LOAD;
        bitClk_d   = 1'b0;
        m1Marker_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      m1State_q  <= M1_GAP;
      m1Cnt_q    <= M1_GAP_LOAD;
      m1Slot_q   <= 4'h0;
      bitClk_q   <= 1'b0;
      m1Marker_q <= 1'b0;
    end else begin
      m1State_q  <= m1State_d;
      m1Cnt_q    <= m1Cnt_d;
      m1Slot_q   <= m1Slot_d;
      bitClk_q   <= bitClk_d;
      m1Marker_q <= m1Marker_d;
    end
  end

  // The synchronised pins lag by four cycles, so the half period must
  // exceed that; the terminal equipment holds them until the next rising edge.
  always_ff @(posedge clk) begin
    if (rst) begin
      m1Ins_q <= '0;
    end else if (m1Latch) begin
      m1Ins_q <= '{slot: m1Slot_q, req: syncReq, data: syncBit};
    end
  end

  assign ohBitClock          = bitClk_q;
  assign ohFrameMarkerBitClk = m1Marker_q;

  // Method 2: the strobe stands for one line clock period, the next period is a
  // wait, and the pins are taken on the rising edge after that, which is the
  // second rising edge after the terminal equipment saw the strobe.
  assign m2CntZero = (m2Cnt_q == 16'h0000);
  assign m2Latch   = (m2State_q == M2_LAT);

  always_comb begin
    m2State_d  = m2State_q;
    m2Cnt_d    = m2Cnt_q;
    m2Slot_d   = m2Slot_q;
    strobe_d   = 1'b0;
    m2Marker_d = 1'b0;
    case (m2State_q)
      M2_GAP: begin
        if (!linkMethod) begin
          m2Cnt_d = M2_GAP_LOAD;
        end else if (m2CntZero) begin
          m2State_d  = M2_STB;
          m2Slot_d   = `OHI_SLOT_FIRST;
          strobe_d   = 1'b1;
          m2Marker_d = 1'b1;
        end else begin
          m2Cnt_d = m2Cnt_q - 16'h0001;
        end
      end
      M2_STB: begin
        m2State_d = M2_LAT;
      end
      M2_LAT: begin
        if (m2Slot_q == `OHI_SLOT_LAST) begin
          m2State_d = M2_GAP;
          m2Cnt_d   = M2_GAP_LOAD;
        end else begin
          m2State_d = M2_STB;
          m2Slot_d  = m2Slot_q + 4'h1;
          strobe_d  = 1'b1;
        end
      end
      default: begin
        m2State_d = M2_GAP;
        m2Cnt_d   = M2_GAP_LOAD;
      end
    endcase
  end

  always_ff @(posedge txLineInputClock) begin
    if (linkRst) begin
      m2State_q  <= M2_GAP;
      m2Cnt_q    <= M2_GAP_LOAD;
      m2Slot_q   <= 4'h0;
      strobe_q   <= 1'b0;
      m2Marker_q <= 1'b0;
    end else begin
      m2State_q  <= m2State_d;
      m2Cnt_q    <= m2Cnt_d;
      m2Slot_q   <= m2Slot_d;
      strobe_q   <= strobe_d;
      m2Marker_q <= m2Marker_d;
    end
  end

  // The terminal equipment drives its pins from this same clock, so they are
  // taken directly; the word then stands until the next slot while the toggle
  // tells the system clock side that it is ready.
  always_ff @(posedge txLineInputClock) begin
    if (linkRst) begin
      linkWord_q <= '0;
      linkTog_q  <= 1'b0;
    end else if (m2Latch) begin
      linkWord_q <= '{slot: m2Slot_q, req: ohInsertRequest, data: ohBitIn};
      linkTog_q  <= ~linkTog_q;
    end
  end

  assign ohSlotStrobe         = strobe_q;
  assign ohFrameMarkerLineClk = m2Marker_q;

  // A toggle seen on the system side means the word has been still for at
  // least three system cycles. Slots are two line clock periods apart, so the
  // word is read well before it can change again.
  assign m2New = (syncTog != togSeen_q);

  always_ff @(posedge clk) begin
    if (rst) begin
      togSeen_q <= 1'b0;
      m2Word_q  <= '0;
    end else begin
      togSeen_q <= syncTog;
      if (m2New) begin
        m2Word_q <= linkWord_q;
      end
    end
  end

  // Words from method 2 are delivered one cycle after capture; method 1 slots
  // are delivered at the end of each bit clock low phase.
  logic m2Pending_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      m2Pending_q <= 1'b0;
    end else begin
      m2Pending_q <= m2New && syncMethod;
    end
  end

  assign srcValid = m1Done || m2Pending_q;
  assign srcIns   = m2Pending_q ? m2Word_q : m1Ins_q;
  assign insertOk = srcIns.req && isInsertable(srcIns.slot);

  always_comb begin
    slotOut_d          = '0;
    slotOut_d.valid    = srcValid;
    slotOut_d.slot     = srcIns.slot;
    slotOut_d.inserted = srcValid && insertOk;
    slotOut_d.refused  = srcValid && srcIns.req && !isInsertable(srcIns.slot);
    if (insertOk) begin
      slotOut_d.value = srcIns.data;
    end else begin
      slotOut_d.value = intOhBits[srcIns.slot];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      slotOut_q <= '0;
    end else begin
      slotOut_q <= slotOut_d;
    end
  end

  assign slotOut = slotOut_q;

endmodule

// ===== rtl/ohi_regs.svh
`ifndef OHI_REGS_SVH
`define OHI_REGS_SVH

// How it works
// - Method 1 samples request and data on the next bit clock falling edge.
// - The A bit sits at bit clock edge 10 after the marker edge.
// - A sampled request places its data into that slot of the outbound frame.
// - Method 2 latches data on a rising edge of the line input clock.
// - Slot strobe is high exactly one line clock period before each overhead bit.
// - Marker accompanies the strobe only for the first overhead bit of a frame.
// - Only slots 10 and 11 accept inserted values; all others are fixed.
// - Method 2 latches data on the second line clock rising edge after strobe.

// Overhead slot numbering within one frame.
`define OHI_SLOT_FIRST      4'h0
`define OHI_SLOT_A          4'ha
`define OHI_SLOT_N          4'hb
`define OHI_SLOT_LAST       4'hf

// Timing counts in system clock cycles (bit clock half period, gaps between frames).
`define OHI_M1_HALF_CYCLES  8
`define OHI_M1_GAP_CYCLES   32
// Timing count in line clock cycles between overhead groups in method 2.
`define OHI_M2_GAP_CYCLES   32

`endif

// ===== rtl/ohi_pkg.sv
package ohi_pkg;

  typedef enum logic [2:0] {
    M1_GAP = 3'b001,
    M1_HI  = 3'b010,
    M1_LO  = 3'b100
  } ohi_m1_state_t;

  typedef enum logic [2:0] {
    M2_GAP = 3'b001,
    M2_STB = 3'b010,
    M2_LAT = 3'b100
  } ohi_m2_state_t;

  // One latched insertion attempt, as seen at a slot.
  typedef struct packed {
    logic [3:0] slot;
    logic       req;
    logic       data;
  } ohi_ins_t;

  // One overhead bit handed to the framer.
  typedef struct packed {
    logic       valid;
    logic [3:0] slot;
    logic       value;
    logic       inserted;
    logic       refused;
  } ohi_slot_t;

endpackage

// ===== rtl/ohi_sync.sv
`timescale 1ns/1ps

// Three-stage synchroniser; the output changes once stages two and three agree.
// It has no reset so that it can also carry a reset into another domain.
module ohi_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage3_q;
  logic [WIDTH-1:0] agreed_q;
  logic [WIDTH-1:0] agreed_d;

  assign agreed_d = (stage2_q & stage3_q) | (agreed_q & (stage2_q | stage3_q));
  assign syncOut  = agreed_q;

  always_ff @(posedge clk) begin
    stage1_q <= asyncIn;
    stage2_q <= stage1_q;
    stage3_q <= stage2_q;
    agreed_q <= agreed_d;
  end

endmodule

// ===== verification/ohi_tx_overhead_insert_asserts.sv
`timescale 1ns/1ps
`include "ohi_regs.svh"

module ohi_tx_overhead_insert_asserts import ohi_pkg::*; #(
  parameter int M1_HALF_CYCLES = 8
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        txLineInputClock,
  input  wire logic        ohMethodSel,
  input  wire logic        ohInsertRequest,
  input  wire logic        ohBitIn,
  input  wire logic [15:0] intOhBits,
  input  wire logic        ohBitClock,
  input  wire logic        ohFrameMarkerBitClk,
  input  wire logic        ohFrameMarkerLineClk,
  input  wire logic        ohSlotStrobe,
  input  wire ohi_slot_t   slotOut
);
  // The fall is seen one tick late and the result register adds one, so the two cancel.
  localparam int M1_LAT = M1_HALF_CYCLES;
  wire logic insSlot = slotOut.slot == `OHI_SLOT_A || slotOut.slot == `OHI_SLOT_N;

  bitclk_high_a: assert property (@(posedge clk) disable iff (rst)
    $rose(ohBitClock) |-> ##M1_HALF_CYCLES $fell(ohBitClock)) else $error("bit clock high phase");
  frame_start_a: assert property (@(posedge clk) disable iff (rst)
    $rose(ohFrameMarkerBitClk) |=> $rose(ohBitClock)) else $error("marker not before edge 0");
  m1_answer_a: assert property (@(posedge clk) disable iff (rst)
    $fell(ohBitClock) && !ohMethodSel |-> ##M1_LAT slotOut.valid) else $error("slot late");
  valid_pulse_a: assert property (@(posedge clk) disable iff (rst)
    slotOut.valid |=> !slotOut.valid) else $error("slot valid too long");
  fixed_slot_a: assert property (@(posedge clk) disable iff (rst)
    slotOut.valid && !insSlot |-> !slotOut.inserted) else $error("fixed slot inserted");
  own_value_a: assert property (@(posedge clk) disable iff (rst)
    slotOut.valid && !slotOut.inserted |-> slotOut.value == intOhBits[slotOut.slot])
    else $error("framer value lost");
  refuse_flag_a: assert property (@(posedge clk) disable iff (rst)
    slotOut.valid && slotOut.refused |-> !insSlot && !slotOut.inserted)
    else $error("bad refusal");
  strobe_pulse_a: assert property (@(posedge txLineInputClock) disable iff (rst)
    $rose(ohSlotStrobe) |=> !ohSlotStrobe) else $error("strobe longer than one period");
  marker_pair_a: assert property (@(posedge txLineInputClock) disable iff (rst)
    ohFrameMarkerLineClk |-> ohSlotStrobe) else $error("marker without strobe");
  next_strobe_a: assert property (@(posedge txLineInputClock) disable iff (rst)
    ohFrameMarkerLineClk |-> ##2 ohSlotStrobe && !ohFrameMarkerLineClk)
    else $error("slot 1 strobe missing");

  ins_c: cover property (@(posedge clk) slotOut.valid && slotOut.inserted);
  ref_c: cover property (@(posedge clk) slotOut.valid && slotOut.refused);
  frm_c: cover property (@(posedge txLineInputClock) ohFrameMarkerLineClk);
endmodule

bind ohi_tx_overhead_insert ohi_tx_overhead_insert_asserts #(
  .M1_HALF_CYCLES(M1_HALF_CYCLES)
) chk (
  .clk(clk), .rst(rst), .txLineInputClock(txLineInputClock), .ohMethodSel(ohMethodSel),
  .ohInsertRequest(ohInsertRequest), .ohBitIn(ohBitIn), .intOhBits(intOhBits),
  .ohBitClock(ohBitClock), .ohFrameMarkerBitClk(ohFrameMarkerBitClk),
  .ohFrameMarkerLineClk(ohFrameMarkerLineClk), .ohSlotStrobe(ohSlotStrobe),
  .slotOut(slotOut)
);

// ===== verification/ohi_term_model.sv
`timescale 1ns/1ps

// Terminal equipment: requests vals[k] at every slot k whose want bit is set, fixed
// slots included, so that refusals can be provoked. Idle data toggles so stale values fail.
module ohi_term_model (
  input  wire logic        method,
  input  wire logic [15:0] want,
  input  wire logic [15:0] vals,
  input  wire logic        ohBitClock,
  input  wire logic        ohFrameMarkerBitClk,
  input  wire logic        txLineInputClock,
  input  wire logic        ohFrameMarkerLineClk,
  input  wire logic        ohSlotStrobe,
  output logic             ohInsertRequest,
  output logic             ohBitIn
);
  logic [4:0] k1 = 5'h10;
  logic [4:0] k2 = 5'h10;
  logic       req1 = 1'b0;
  logic       req2 = 1'b0;
  logic       dat1 = 1'b0;
  logic       dat2 = 1'b0;

  always @(posedge ohBitClock) begin
    k1 = ohFrameMarkerBitClk ? 5'h0 : k1 + 5'h1;
    req1 <= k1 < 5'h10 && want[k1[3:0]];
    dat1 <= (k1 < 5'h10 && want[k1[3:0]]) ? vals[k1[3:0]] : !dat1;
  end

  always @(negedge txLineInputClock) begin
    if (ohSlotStrobe) begin
      k2 = ohFrameMarkerLineClk ? 5'h0 : k2 + 5'h1;
      req2 <= k2 < 5'h10 && want[k2[3:0]];
      dat2 <= (k2 < 5'h10 && want[k2[3:0]]) ? vals[k2[3:0]] : !dat2;
    end
  end

  assign ohInsertRequest = method ? req2 : req1;
  assign ohBitIn = method ? dat2 : dat1;
endmodule

// ===== verification/e3_tx_overhead_bit_insertion_tb.sv
`timescale 1ns/1ps

module e3_tx_overhead_bit_insertion_tb import ohi_pkg::*;;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        txLineInputClock = 1'b0;
  logic        ohMethodSel = 1'b0;
  logic [15:0] intOhBits = 16'h0;
  logic [15:0] want = 16'h0;
  logic [15:0] vals = 16'h0;
  logic        ohInsertRequest;
  logic        ohBitIn;
  logic        ohBitClock;
  logic        ohFrameMarkerBitClk;
  logic        ohFrameMarkerLineClk;
  logic        ohSlotStrobe;
  ohi_slot_t   slotOut;
  int          failures = 0;
  int          numChecks = 0;

  initial forever #4 clk = ~clk;
  initial begin
    #5.3;
    forever #16 txLineInputClock = ~txLineInputClock;
  end

  // Short gaps keep the run brief; slot timing itself is left at its real length.
  ohi_tx_overhead_insert #(.M1_HALF_CYCLES(8), .M1_GAP_CYCLES(4), .M2_GAP_CYCLES(2)) dut (
    .clk(clk), .rst(rst), .txLineInputClock(txLineInputClock), .ohMethodSel(ohMethodSel),
    .ohInsertRequest(ohInsertRequest), .ohBitIn(ohBitIn), .intOhBits(intOhBits),
    .ohBitClock(ohBitClock), .ohFrameMarkerBitClk(ohFrameMarkerBitClk),
    .ohFrameMarkerLineClk(ohFrameMarkerLineClk), .ohSlotStrobe(ohSlotStrobe),
    .slotOut(slotOut));

  ohi_term_model term (
    .method(ohMethodSel), .want(want), .vals(vals), .ohBitClock(ohBitClock),
    .ohFrameMarkerBitClk(ohFrameMarkerBitClk), .txLineInputClock(txLineInputClock),
    .ohFrameMarkerLineClk(ohFrameMarkerLineClk), .ohSlotStrobe(ohSlotStrobe),
    .ohInsertRequest(ohInsertRequest), .ohBitIn(ohBitIn));

  task automatic check(input ohi_slot_t seen, input ohi_slot_t exp);
    numChecks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t slot %0d got %h expected %h", $time, exp.slot, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  function automatic ohi_slot_t expSlot(input logic [3:0] s);
    ohi_slot_t e;
    logic      open;
    open = s == 4'ha || s == 4'hb;
    e.valid = 1'b1;
    e.slot = s;
    e.inserted = open && want[s];
    e.refused = !open && want[s];
    e.value = e.inserted ? vals[s] : intOhBits[s];
    return e;
  endfunction

  initial begin
    int n;
    void'($urandom(32'hd87ae6b4));
    // Tests 0-1 send remote defect only, 2-3 random requests, 4-5 a request at every slot.
    for (int t = 0; t < 6; t++) begin
      @(posedge clk);
      rst <= 1'b1;
      ohMethodSel <= t[0];
      want <= (t < 2) ? 16'h0400 : (t < 4) ? 16'($urandom) : 16'hffff;
      vals <= (t < 2) ? 16'hffff : 16'($urandom);
      intOhBits <= (t < 2) ? 16'h0000 : 16'($urandom);
      repeat (40) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 32; i++) begin
        n = 0;
        do begin
          @(negedge clk);
          n++;
        end while (slotOut.valid !== 1'b1 && n < 1000);
        if (n >= 1000) begin
          failures++;
          $display("BAD %0t no slot seen", $time);
          results();
        end
        check(slotOut, expSlot(4'(i)));
      end
      $display("test %0d method %0d done", t, t[0]);
    end
    results();
  end
endmodule
